// [logic/direct_bank_address_mapper.sv]
// direct bank address mapper: operand relocation and region decode
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R01] direct operands 0x00-0x7F never relocated
// [R02] bank select resets zero, identity mapping
// [R03] banks 1-7 map onto 128-byte windows
// [R04] window beyond implemented RAM is unusable
// [R05] register area doubles as plain RAM
// [R06] top flash words hold vector table
// [R07] flash 0xFFBB-0xFFBF keeps non-volatile data
// [R08] 0x0078 mirrors both bank selects
// [R09] software never writes disabled addresses
// [R10] relocation combinational, new bank next access
module direct_bank_address_mapper
    import bank_map_pkg::*;
#(
    parameter logic [15:0] RAM_LAST    = RAM_LAST_DFLT,
    parameter logic [15:0] FLASH_FIRST = FLASH_FIRST_DFLT
)
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire access_req_t req_i,
    output var  access_rsp_t rsp_o,
    output var  logic [2:0]  direct_bank_select_o,
    output var  logic [4:0]  register_bank_select_o
);

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    function automatic region_t decode(input logic [15:0] a);
        region_t r;
        r = REG_PROHIBITED;
        // vector and nvr ranges sit inside flash, so test them first
        if (a <= IO_LAST)
        begin
            r = REG_IO;
        end
        else if (a >= RAM_FIRST && a <= RAM_LAST)
        begin
            // [R04] anything above RAM_LAST and below EXT_IO_FIRST stays prohibited
            r = REG_RAM;
            if (a >= GPR_FIRST && a <= GPR_LAST)
            begin
                r = REG_GPR_RAM; // [R05]
            end
        end
        else if (a >= EXT_IO_FIRST && a <= EXT_IO_LAST)
        begin
            r = REG_EXT_IO;
        end
        else if (a >= VECTOR_FIRST)
        begin
            r = REG_VECTOR; // [R06]
        end
        else if (a >= NVR_FIRST && a <= NVR_LAST)
        begin
            r = REG_NVR_DATA; // [R07]
        end
        else if (a >= FLASH_FIRST)
        begin
            r = REG_FLASH;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // bank select state
    // ------------------------------------------------------------
    logic [2:0]  dbs_q;
    logic [2:0]  dbs_d;
    logic [4:0]  rbs_q;
    logic [4:0]  rbs_d;
    logic [15:0] dir_phys;
    logic [15:0] reg_phys;
    logic [15:0] phys;
    logic        mirror_hit;

    // ------------------------------------------------------------
    // direct operand relocation
    // ------------------------------------------------------------
    // address formation reads only the current registers, so a bank
    // change written in one cycle steers the access in the next one
    always_comb
    begin
        if (req_i.operand[7:0] <= DIRECT_FIXED_LAST)
        begin
            dir_phys = {8'h00, req_i.operand[7:0]}; // [R01]
        end
        else if (dbs_q == DBS_RESET)
        begin
            // bank zero keeps the short range on its own ram
            dir_phys = {8'h00, req_i.operand[7:0]}; // [R02]
        end
        else
        begin
            // bank k lands at 0x0080 + k*0x80
            dir_phys = BANK_WINDOW_BASE
                     + (16'(dbs_q) << BANK_SHIFT)
                     + {9'h000, req_i.operand[6:0]}; // [R03] [R10]
        end
    end

    // ------------------------------------------------------------
    // register addressing
    // ------------------------------------------------------------
    // eight registers per bank over the same ram cells, so a register
    // access and a linear access of that address share one storage
    always_comb
    begin
        reg_phys = GPR_FIRST
                 + (16'(rbs_q) << GPR_BANK_SHIFT)
                 + {13'h0000, req_i.operand[2:0]}; // [R05]
    end

    // ------------------------------------------------------------
    // address select
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (req_i.kind)
            ACC_DIRECT:
            begin
                phys = dir_phys;
            end
            ACC_REGISTER:
            begin
                phys = reg_phys;
            end
            ACC_LINEAR:
            begin
                phys = req_i.operand;
            end
            default:
            begin
                // unused kind code: pass the operand through untouched
                phys = req_i.operand;
            end
        endcase
    end

    // ------------------------------------------------------------
    // mirror of both bank selects
    // ------------------------------------------------------------
    // decoded on the relocated address, so a direct operand of 0x78
    // reaches the mirror whatever the bank select holds
    assign mirror_hit = req_i.valid && (phys == MIRROR_ADDR);

    always_comb
    begin
        dbs_d = dbs_q;
        rbs_d = rbs_q;
        // a write to a disabled address is not guarded here; the
        // software side keeps away from them
        if (mirror_hit && req_i.write)
        begin
            dbs_d = req_i.wdata[MIRROR_DBS_LSB +: 3]; // [R08]
            rbs_d = req_i.wdata[MIRROR_RBS_LSB +: 5]; // [R08]
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dbs_q <= DBS_RESET; // [R02]
            rbs_q <= RBS_RESET;
        end
        else
        begin
            dbs_q <= dbs_d;
            rbs_q <= rbs_d;
        end
    end

    // ------------------------------------------------------------
    // response register
    // ------------------------------------------------------------
    // registered so that every output comes from a flip-flop
    access_rsp_t rsp_d;
    access_rsp_t rsp_q;

    always_comb
    begin
        rsp_d              = '0;
        rsp_d.valid        = req_i.valid;
        rsp_d.phys_addr    = phys;
        rsp_d.region       = decode(phys);
        rsp_d.mirror_hit   = mirror_hit;
        // read shows the values before any same-cycle write
        rsp_d.mirror_rdata = {rbs_q, dbs_q}; // [R08]
        if (!req_i.valid)
        begin
            rsp_d.phys_addr    = '0;
            rsp_d.region       = REG_IO;
            rsp_d.mirror_rdata = '0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp_o                  = rsp_q;
    assign direct_bank_select_o   = dbs_q;
    assign register_bank_select_o = rbs_q;

endmodule
`default_nettype wire

// [include/bank_map_pkg.sv]
// constants and carriers for the direct bank address mapper
`default_nettype none
package bank_map_pkg;

    // ------------------------------------------------------------
    // address space layout
    // ------------------------------------------------------------
    localparam logic [15:0] IO_FIRST        = 16'h0000;
    localparam logic [15:0] IO_LAST         = 16'h007F;
    localparam logic [15:0] RAM_FIRST       = 16'h0090;
    localparam logic [15:0] RAM_LAST_DFLT   = 16'h047F;
    localparam logic [15:0] GPR_FIRST       = 16'h0100;
    localparam logic [15:0] GPR_LAST        = 16'h01FF;
    localparam logic [15:0] EXT_IO_FIRST    = 16'h0F80;
    localparam logic [15:0] EXT_IO_LAST     = 16'h0FFF;
    localparam logic [15:0] FLASH_FIRST_DFLT = 16'h8000;
    localparam logic [15:0] NVR_FIRST       = 16'hFFBB;
    localparam logic [15:0] NVR_LAST        = 16'hFFBF;
    localparam logic [15:0] VECTOR_FIRST    = 16'hFFC0;
    localparam logic [15:0] MIRROR_ADDR     = 16'h0078;

    // ------------------------------------------------------------
    // direct addressing and banks
    // ------------------------------------------------------------
    localparam logic [7:0]  DIRECT_FIXED_LAST = 8'h7F;
    localparam logic [15:0] BANK_WINDOW_BASE  = 16'h0080;
    localparam int          BANK_SHIFT        = 7;
    localparam logic [2:0]  DBS_RESET         = 3'h0;
    localparam logic [4:0]  RBS_RESET         = 5'h00;
    localparam int          GPR_BANK_SHIFT    = 3;

    // mirror byte layout: register bank select above direct bank select
    localparam int MIRROR_DBS_LSB = 0;
    localparam int MIRROR_RBS_LSB = 3;

    typedef enum logic [1:0] {
        ACC_DIRECT,
        ACC_REGISTER,
        ACC_LINEAR
    } access_kind_t;

    typedef enum logic [3:0] {
        REG_IO,
        REG_PROHIBITED,
        REG_RAM,
        REG_GPR_RAM,
        REG_EXT_IO,
        REG_FLASH,
        REG_NVR_DATA,
        REG_VECTOR
    } region_t;

    typedef struct packed {
        logic         valid;
        logic         write;
        access_kind_t kind;
        logic [15:0]  operand;
        logic [7:0]   wdata;
    } access_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] phys_addr;
        region_t     region;
        logic        mirror_hit;
        logic [7:0]  mirror_rdata;
    } access_rsp_t;

endpackage
`default_nettype wire

// [sim/cpu_addr_gen_model.sv]
// model of the cpu address generation feeding the mapper
`timescale 1ns/100ps
`default_nettype none
module cpu_addr_gen_model
    import bank_map_pkg::*;
(
    input  wire logic         issue_i,
    input  wire access_kind_t kind_i,
    input  wire logic [15:0]  addr_i,
    input  wire logic         write_i,
    input  wire logic [7:0]   wdata_i,
    output var  access_req_t  req_o
);
    // writes only reach the mirror: other places may be disabled
    assign req_o = !issue_i ? access_req_t'('0) : access_req_t'{
        valid: 1'b1,
        kind: kind_i,
        write: write_i && addr_i == MIRROR_ADDR,
        operand: addr_i,
        wdata: wdata_i};
endmodule
`default_nettype wire

// [sim/direct_bank_address_mapper_chk.sv]
// checker for the direct bank address mapper
`timescale 1ns/100ps
`default_nettype none
module direct_bank_address_mapper_chk
    import bank_map_pkg::*;
#(parameter logic [15:0] RAM_LAST = RAM_LAST_DFLT)
(
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire access_req_t req_i,
    input wire access_rsp_t rsp_o,
    input wire logic [2:0]  direct_bank_select_o,
    input wire logic [4:0]  register_bank_select_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic dir   = req_i.valid && req_i.kind == ACC_DIRECT;
    wire logic dir_h = dir && req_i.operand[7];
    wire logic ph_ok = rsp_o.valid;
    property p_valid; req_i.valid |=> rsp_o.valid; endproperty
    a_valid: assert property (p_valid) else $error("no response");
    property p_fixed; dir && !req_i.operand[7] |=>
        rsp_o.phys_addr == {8'h00, $past(req_i.operand[7:0])}; endproperty
    a_fixed: assert property (p_fixed) else $error("low moved");
    property p_bank0; dir_h && direct_bank_select_o == 3'h0 |=>
        rsp_o.phys_addr == {8'h00, $past(req_i.operand[7:0])}; endproperty
    a_bank0: assert property (p_bank0) else $error("bank 0 map");
    property p_bankn; dir_h && direct_bank_select_o != 3'h0 |=>
        rsp_o.phys_addr == 16'h0080 + {6'h00, $past(direct_bank_select_o),
        $past(req_i.operand[6:0])}; endproperty
    a_bankn: assert property (p_bankn) else $error("bank map");
    property p_end; ph_ok && rsp_o.phys_addr > RAM_LAST && rsp_o.phys_addr
        < EXT_IO_FIRST |-> rsp_o.region == REG_PROHIBITED; endproperty
    a_end: assert property (p_end) else $error("past ram end");
    property p_gpr; ph_ok && rsp_o.phys_addr inside {[GPR_FIRST:GPR_LAST]}
        && rsp_o.phys_addr <= RAM_LAST |-> rsp_o.region == REG_GPR_RAM;
    endproperty
    a_gpr: assert property (p_gpr) else $error("gpr region");
    property p_vec; ph_ok && rsp_o.phys_addr >= VECTOR_FIRST
        |-> rsp_o.region == REG_VECTOR; endproperty
    a_vec: assert property (p_vec) else $error("vector region");
    property p_nvr; ph_ok && rsp_o.phys_addr inside {[NVR_FIRST:NVR_LAST]}
        |-> rsp_o.region == REG_NVR_DATA; endproperty
    a_nvr: assert property (p_nvr) else $error("nvr region");
    property p_mir; req_i.valid && req_i.write && req_i.operand ==
        MIRROR_ADDR && req_i.kind == ACC_LINEAR |=> rsp_o.mirror_hit &&
        {register_bank_select_o, direct_bank_select_o} == $past(req_i.wdata);
    endproperty
    a_mir: assert property (p_mir) else $error("mirror write");
    property p_reg; req_i.valid && req_i.kind == ACC_REGISTER |=>
        rsp_o.phys_addr == {8'h01, $past(register_bank_select_o),
        $past(req_i.operand[2:0])}; endproperty
    a_reg: assert property (p_reg) else $error("register map");
    property p_rdata; ph_ok |-> rsp_o.mirror_rdata ==
        {$past(register_bank_select_o), $past(direct_bank_select_o)};
    endproperty
    a_rdata: assert property (p_rdata) else $error("mirror read");
    c_bank7: cover property (dir_h && direct_bank_select_o == 3'h7);
    c_vec: cover property (ph_ok && rsp_o.region == REG_VECTOR);
    c_mir: cover property (ph_ok && rsp_o.mirror_hit);
endmodule
bind direct_bank_address_mapper direct_bank_address_mapper_chk
    #(.RAM_LAST(RAM_LAST)) i_chk (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .req_i(req_i), .rsp_o(rsp_o),
    .direct_bank_select_o(direct_bank_select_o),
    .register_bank_select_o(register_bank_select_o));
`default_nettype wire

// [sim/direct_bank_address_mapper_tb_top.sv]
// self-checking bench for the direct bank address mapper
`timescale 1ns/100ps
`default_nettype none
module direct_bank_address_mapper_tb_top
    import bank_map_pkg::*;
;
    logic         sys_clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic         issue = 1'b0;
    logic         write = 1'b0;
    access_kind_t kind = ACC_DIRECT;
    logic [15:0]  addr = 16'h0000;
    logic [15:0]  pa;
    logic [7:0]   wdata = 8'h00;
    logic [7:0]   o;
    logic [4:0]   r;
    access_req_t  req;
    access_rsp_t  rsp;
    logic [2:0]   dbs;
    logic [4:0]   rbs;
    logic [19:0]  exp_q[$];
    int           mismatches = 0;
    int           num_checks = 0;
    int           seed = 32'h12F448A4;
    logic [15:0]  lin [6] = '{16'h0F80, 16'h8000, 16'hFFBB, 16'hFFBF,
                              16'hFFC0, 16'h0480};
    region_t      lreg [6] = '{REG_EXT_IO, REG_FLASH, REG_NVR_DATA,
                               REG_NVR_DATA, REG_VECTOR, REG_PROHIBITED};
    always #5 sys_clk_i = ~sys_clk_i;
    cpu_addr_gen_model i_cpu_addr_gen_model (.issue_i(issue), .kind_i(kind),
        .addr_i(addr), .write_i(write), .wdata_i(wdata), .req_o(req));
    direct_bank_address_mapper i_direct_bank_address_mapper (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req),
        .rsp_o(rsp), .direct_bank_select_o(dbs),
        .register_bank_select_o(rbs));
    function automatic region_t ereg(input logic [15:0] a);
        if (a <= IO_LAST) return REG_IO;
        if (a < RAM_FIRST) return REG_PROHIBITED;
        if (a >= GPR_FIRST && a <= GPR_LAST) return REG_GPR_RAM;
        return REG_RAM;
    endfunction
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bank(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input access_kind_t k, input logic [15:0] a,
        input logic w, input logic [7:0] d, input logic [15:0] e,
        input region_t g);
        issue = 1'b1;
        kind = k;
        addr = a;
        write = w;
        wdata = d;
        exp_q.push_back({e, g});
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic finish_test();
        if (exp_q.size() != 0) mismatches++;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // the response lands one edge after the request
    always @(posedge sys_clk_i)
    begin
        #2;
        if (rsp.valid === 1'b1 && exp_q.size() > 0)
            cmp({rsp.phys_addr, rsp.region}, exp_q.pop_front());
    end
    initial
    begin
        repeat (3) @(posedge sys_clk_i);
        #1 resetn_i = 1'b1;
        cmp_bank({rbs, dbs}, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            r = 5'($random(seed));
            o = 8'($random(seed)) | 8'h80;
            pa = (k == 0) ? {8'h00, o} : 16'h0080 + 16'(k << 7) + 16'(o[6:0]);
            acc(ACC_LINEAR, MIRROR_ADDR, 1'b1, {r, 3'(k)}, MIRROR_ADDR,
                REG_IO);
            cmp_bank({rbs, dbs}, {r, 3'(k)});
            acc(ACC_DIRECT, {8'h00, o}, 1'b0, 8'h00, pa, ereg(pa));
            acc(ACC_DIRECT, 16'(o[6:0]), 1'b0, 8'h00, 16'(o[6:0]),
                REG_IO);
            acc(ACC_REGISTER, 16'(o[2:0]), 1'b0, 8'h00,
                GPR_FIRST + 16'({r, o[2:0]}), REG_GPR_RAM);
        end
        $display("test banks done");
        for (int i = 0; i < 6; i++)
            acc(ACC_LINEAR, lin[i], 1'b0, 8'h00, lin[i],
                lreg[i]);
        issue = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        $display("test regions done");
        finish_test();
    end
    initial
    begin
        #20000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
